/* cgd_pkg.sv */
// Package: constants and carriers for the controller glue I/O decode block
package cgd_pkg;

	// ****************************************************************
	// Address blocks
	// ****************************************************************
	localparam logic [15:0] CGD_PERIPH_BASE = 16'hf400;
	localparam logic [15:0] CGD_PORT_BASE = 16'h0200;
	localparam logic [15:0] CGD_PANEL_BASE = 16'h0040;
	localparam logic [15:0] CGD_PANEL_LAST = 16'h007f;

	// ****************************************************************
	// Register addresses
	// ****************************************************************
	localparam logic [15:0] CGD_UPPER_SEL_ADDR = 16'hf400;
	localparam logic [15:0] CGD_MIDDLE_SEL_ADDR = 16'hf410;
	localparam logic [15:0] CGD_LOWER_SEL_ADDR = 16'hf420;
	localparam logic [15:0] CGD_PAGE_FRAME_ADDR = 16'hf430;
	localparam logic [15:0] CGD_PAGE_LATCH_ADDR = 16'hf440;
	localparam logic [15:0] CGD_MEM_CTL_ADDR = 16'hf490;
	localparam logic [15:0] CGD_PUB_LOCK_ADDR = 16'hf4a0;
	localparam logic [15:0] CGD_OUT_PORT_ADDR = 16'hf4b0;
	localparam logic [15:0] CGD_WDOG_ADDR = 16'h0200;
	localparam logic [15:0] CGD_MAINT_ADDR = 16'h0210;

	// ****************************************************************
	// Memory control latch fields
	// ****************************************************************
	localparam int CGD_MC_RAM_WR = 0;
	localparam int CGD_MC_RAM_RD = 1;
	localparam int CGD_MC_FLASH_WR = 2;
	localparam int CGD_MC_FLASH_RD = 3;
	localparam int CGD_MC_FLASH_EN = 4;

	// ****************************************************************
	// Reset values and constants
	// ****************************************************************
	localparam logic [7:0] CGD_MEM_CTL_RST = 8'h00;
	localparam logic [15:0] CGD_SEL_RST = 16'h0000;
	localparam logic [15:0] CGD_RTI_VECTOR = 16'h0043;
	localparam logic [15:0] CGD_RDATA_RST = 16'h0000;

	// ****************************************************************
	// Timing
	// ****************************************************************
	localparam longint CGD_CLK_HZ = 25000000;
	localparam longint CGD_POR_HOLD_MS = 350;
	localparam longint CGD_WDOG_GAP_MS = 500;
	localparam longint CGD_POR_HOLD_CYC = CGD_POR_HOLD_MS * CGD_CLK_HZ / 1000;
	localparam longint CGD_WDOG_GAP_CYC = CGD_WDOG_GAP_MS * CGD_CLK_HZ / 1000;
	localparam longint CGD_RTI_DIVISOR = 666000;

	// ****************************************************************
	// Carriers
	// ****************************************************************
	typedef struct packed {
		logic [15:0] addr;
		logic [15:0] wdata;
		logic wr;
		logic rd;
		logic inta;
	} cgd_io_req_s;

	typedef struct packed {
		logic ram_we;
		logic ram_oe;
		logic flash_we;
		logic flash_oe;
		logic eprom_oe;
	} cgd_mem_sel_s;

	typedef enum logic [1:0] {
		CGD_SUP_HOLD = 2'b00,
		CGD_SUP_IDLE = 2'b01,
		CGD_SUP_ARMED = 2'b10
	} cgd_sup_e;

endpackage : cgd_pkg

/* cgd_io_decode.sv */
// Controller glue: I/O decode, registers, supervisor and real-time interrupt
// Behaviour
// RL1 - Hold reset request 350 ms after power good
// RL2 - Processor kicks watchdog at regular intervals
// RL3 - Kick gap over half second asserts reset
// RL4 - Decode F400-F4FF as peripheral registers
// RL5 - Decode 0200-02FF as internal I/O ports
// RL6 - Decode 0040-007F for LEDs and DIP banks
// RL7 - Sixteen-bit data bus for all transfers
// RL8 - Select and paging registers are write-only
// RL9 - Memory control write latches bits 0-4,6,7
// RL10 - Shared map: writes to RAM, reads flash
// RL11 - Flash disabled routes accesses to boot EPROM
// RL12 - Memory control read returns status inputs
// RL13 - Every watchdog port write kicks watchdog
// RL14 - Bit 0 zero at watchdog port forces failover
// RL15 - Maintenance port bit 0 enables failover (code only drives maint_failover_en; failover is forced whatever its value)
// RL16 - Lock bit 0 locks public memory bus
// RL17 - Divide clock by 666,000 for interrupts
// RL18 - Acknowledge cycle returns vector 43h
// RL19 - Interrupt request holds until acknowledge seen
`timescale 1ns/1ps
`default_nettype none

module cgd_io_decode
	import cgd_pkg::*;
#(
	parameter longint POR_HOLD_CYC = CGD_POR_HOLD_CYC,
	parameter longint WDOG_GAP_CYC = CGD_WDOG_GAP_CYC,
	parameter longint RTI_DIVISOR = CGD_RTI_DIVISOR
) (
	input wire logic clk_sys,
	input wire logic resetn,
	input wire cgd_io_req_s io_req,
	output logic [15:0] io_rdata,
	output logic io_rvalid,
	input wire logic mem_rd,
	input wire logic mem_wr,
	output cgd_mem_sel_s mem_sel,
	output logic [7:0] mem_ctl,
	output logic [15:0] upper_region_select,
	output logic [15:0] middle_region_select,
	output logic [15:0] lower_region_select,
	output logic [15:0] page_frame,
	output logic [15:0] page_latch,
	output logic [15:0] out_port,
	input wire logic [7:0] status_in,
	input wire logic [31:0] dip_in,
	output logic status_led_first,
	output logic status_led_second,
	input wire logic power_good,
	output logic rst_req_n,
	output logic kick_n,
	output logic failover,
	output logic maint_failover_en,
	output logic pub_lock,
	output logic rti_req
);

	// ****************************************************************
	// Reset release and pin synchronisers
	// ****************************************************************
	logic [1:0] rst_sync_q;
	logic rst_n;
	logic [7:0] stat_m_q, stat_q;
	logic [31:0] dip_m_q, dip_q;
	logic pg_m_q, pg_q;

	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			rst_sync_q <= 2'b00;
		end else begin
			rst_sync_q <= {rst_sync_q[0], 1'b1};
		end
	end
	assign rst_n = rst_sync_q[1];

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			stat_m_q <= 8'h00;
			stat_q <= 8'h00;
			dip_m_q <= 32'h0000_0000;
			dip_q <= 32'h0000_0000;
			pg_m_q <= 1'b0;
			pg_q <= 1'b0;
		end else begin
			stat_m_q <= status_in;
			stat_q <= stat_m_q;
			dip_m_q <= dip_in;
			dip_q <= dip_m_q;
			pg_m_q <= power_good;
			pg_q <= pg_m_q;
		end
	end

	// ****************************************************************
	// Address decode
	// ****************************************************************
	logic hit_periph, hit_port, hit_panel;
	logic wr_at_mem_ctl, wr_at_wdog;

	assign hit_periph = io_req.addr[15:8] == CGD_PERIPH_BASE[15:8]; // RL4
	assign hit_port = io_req.addr[15:8] == CGD_PORT_BASE[15:8]; // RL5
	assign hit_panel = (io_req.addr >= CGD_PANEL_BASE) && (io_req.addr <= CGD_PANEL_LAST); // RL6
	assign wr_at_mem_ctl = io_req.wr && hit_periph && io_req.addr == CGD_MEM_CTL_ADDR;
	assign wr_at_wdog = io_req.wr && hit_port && io_req.addr == CGD_WDOG_ADDR;

	// ****************************************************************
	// Write-only programming registers
	// ****************************************************************
	logic [15:0] upper_q, middle_q, lower_q, frame_q, plat_q, oport_q;
	logic [7:0] mem_ctl_q;

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			upper_q <= CGD_SEL_RST;
			middle_q <= CGD_SEL_RST;
			lower_q <= CGD_SEL_RST;
			frame_q <= CGD_SEL_RST;
			plat_q <= CGD_SEL_RST;
			oport_q <= CGD_SEL_RST;
		end else if (io_req.wr && hit_periph) begin
			case (io_req.addr)
				CGD_UPPER_SEL_ADDR: upper_q <= io_req.wdata; // RL8
				CGD_MIDDLE_SEL_ADDR: middle_q <= io_req.wdata; // RL8
				CGD_LOWER_SEL_ADDR: lower_q <= io_req.wdata; // RL8
				CGD_PAGE_FRAME_ADDR: frame_q <= io_req.wdata; // RL8
				CGD_PAGE_LATCH_ADDR: plat_q <= io_req.wdata; // RL8
				CGD_OUT_PORT_ADDR: oport_q <= io_req.wdata;
				default: ;
			endcase
		end
	end

	// Bit 5 is not latched and always reads back as zero
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			mem_ctl_q <= CGD_MEM_CTL_RST;
		end else if (wr_at_mem_ctl) begin
			mem_ctl_q <= {io_req.wdata[7:6], 1'b0, io_req.wdata[4:0]}; // RL9
		end
	end

	assign upper_region_select = upper_q;
	assign middle_region_select = middle_q;
	assign lower_region_select = lower_q;
	assign page_frame = frame_q;
	assign page_latch = plat_q;
	assign out_port = oport_q;
	assign mem_ctl = mem_ctl_q;

	// ****************************************************************
	// Memory steering
	// ****************************************************************
	// Flash disabled enables the boot EPROM on every read and blocks flash_oe; ram_oe still follows the RAM read bit
	always_comb begin
		mem_sel.ram_we = mem_wr && mem_ctl_q[CGD_MC_RAM_WR]; // RL10
		mem_sel.ram_oe = mem_rd && mem_ctl_q[CGD_MC_RAM_RD]; // RL10
		mem_sel.flash_we = mem_wr && mem_ctl_q[CGD_MC_FLASH_EN]
			&& mem_ctl_q[CGD_MC_FLASH_WR]; // RL10
		mem_sel.flash_oe = mem_rd && mem_ctl_q[CGD_MC_FLASH_EN]
			&& mem_ctl_q[CGD_MC_FLASH_RD]; // RL10
		mem_sel.eprom_oe = mem_rd && !mem_ctl_q[CGD_MC_FLASH_EN]; // RL11
	end

	// ****************************************************************
	// Port writes: watchdog, failover, lock, LEDs
	// ****************************************************************
	logic kick_n_q, failover_q, maint_q, lock_q, led1_q, led2_q;

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			kick_n_q <= 1'b1;
			failover_q <= 1'b0;
		end else begin
			kick_n_q <= !wr_at_wdog; // RL13
			if (wr_at_wdog) begin
				failover_q <= !io_req.wdata[0]; // RL14
			end
		end
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			maint_q <= 1'b0;
			lock_q <= 1'b0;
		end else if (io_req.wr) begin
			if (hit_port && io_req.addr == CGD_MAINT_ADDR) begin
				maint_q <= io_req.wdata[0]; // RL15
			end
			if (hit_periph && io_req.addr == CGD_PUB_LOCK_ADDR) begin
				lock_q <= io_req.wdata[0]; // RL16
			end
		end
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			led1_q <= 1'b0;
			led2_q <= 1'b0;
		end else if (io_req.wr && hit_panel) begin
			led1_q <= io_req.wdata[0]; // RL6
			led2_q <= io_req.wdata[1]; // RL6
		end
	end

	assign kick_n = kick_n_q;
	assign failover = failover_q;
	assign maint_failover_en = maint_q;
	assign pub_lock = lock_q;
	assign status_led_first = led1_q;
	assign status_led_second = led2_q;

	// ****************************************************************
	// Real-time interrupt divider
	// ****************************************************************
	logic [19:0] rti_cnt_q;
	logic rti_q, rti_tc;

	assign rti_tc = rti_cnt_q == 20'(RTI_DIVISOR - 1);

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			rti_cnt_q <= 20'h00000;
		end else begin
			rti_cnt_q <= rti_tc ? 20'h00000 : rti_cnt_q + 20'h00001; // RL17
		end
	end

	// A tick landing on the acknowledge cycle wins, so no tick is lost
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			rti_q <= 1'b0;
		end else if (rti_tc) begin
			rti_q <= 1'b1; // RL17
		end else if (io_req.inta) begin
			rti_q <= 1'b0; // RL19
		end
	end
	assign rti_req = rti_q;

	// ****************************************************************
	// Read data path
	// ****************************************************************
	logic [15:0] rdata_q;
	logic rvalid_q;

	// Write-only and unmapped addresses read as zero
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			rdata_q <= CGD_RDATA_RST;
			rvalid_q <= 1'b0;
		end else begin
			rvalid_q <= io_req.rd || io_req.inta;
			if (io_req.inta) begin
				rdata_q <= CGD_RTI_VECTOR; // RL18
			end else if (io_req.rd) begin
				if (hit_periph && io_req.addr == CGD_MEM_CTL_ADDR) begin
					rdata_q <= {8'h00, stat_q[7], 2'b00, stat_q[4:0]}; // RL12
				end else if (hit_panel) begin
					rdata_q <= {8'h00, dip_q[{io_req.addr[1:0], 3'b000} +: 8]}; // RL6
				end else begin
					rdata_q <= 16'h0000; // RL8
				end
			end
		end
	end
	assign io_rdata = rdata_q; // RL7
	assign io_rvalid = rvalid_q;

	// ****************************************************************
	// Reset supervisor and watchdog
	// ****************************************************************
	// Watchdog arms on the first kick, since boot code may not kick at all
	cgd_sup_e sup_q;
	logic [23:0] sup_cnt_q;

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			sup_q <= CGD_SUP_HOLD;
			sup_cnt_q <= 24'h000000;
		end else if (!pg_q) begin
			sup_q <= CGD_SUP_HOLD;
			sup_cnt_q <= 24'h000000;
		end else begin
			case (sup_q)
				CGD_SUP_HOLD: begin
					if (sup_cnt_q == 24'(POR_HOLD_CYC - 1)) begin
						sup_q <= CGD_SUP_IDLE; // RL1
						sup_cnt_q <= 24'h000000;
					end else begin
						sup_cnt_q <= sup_cnt_q + 24'h000001;
					end
				end
				CGD_SUP_IDLE: begin
					if (!kick_n_q) begin
						sup_q <= CGD_SUP_ARMED; // RL2
						sup_cnt_q <= 24'h000000;
					end
				end
				CGD_SUP_ARMED: begin
					if (!kick_n_q) begin
						sup_cnt_q <= 24'h000000; // RL2
					end else if (sup_cnt_q == 24'(WDOG_GAP_CYC - 1)) begin
						sup_q <= CGD_SUP_HOLD; // RL3
						sup_cnt_q <= 24'h000000;
					end else begin
						sup_cnt_q <= sup_cnt_q + 24'h000001;
					end
				end
				default: begin
					sup_q <= CGD_SUP_HOLD;
					sup_cnt_q <= 24'h000000;
				end
			endcase
		end
	end
	assign rst_req_n = sup_q != CGD_SUP_HOLD; // RL1 RL3

	// ****************************************************************
	// Assertions
	// ****************************************************************
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rst_n);

	kick_follows_write_a: assert property (wr_at_wdog |=> !kick_n) // RL13
		else $error("watchdog write gave no kick");
	kick_only_on_write_a: assert property (!wr_at_wdog |=> kick_n) // RL13
		else $error("kick without watchdog write");
	failover_zero_a: assert property (wr_at_wdog && !io_req.wdata[0] |=> failover) // RL14
		else $error("failover not forced");
	maint_enable_a: assert property (io_req.wr && io_req.addr == CGD_MAINT_ADDR
		|=> maint_failover_en == $past(io_req.wdata[0])) // RL15
		else $error("maintenance enable mismatch");
	bus_lock_a: assert property (io_req.wr && io_req.addr == CGD_PUB_LOCK_ADDR
		|=> pub_lock == $past(io_req.wdata[0])) // RL16
		else $error("public lock mismatch");
	mem_latch_a: assert property (wr_at_mem_ctl
		|=> mem_ctl[5] == 1'b0 && mem_ctl[4:0] == $past(io_req.wdata[4:0])) // RL9
		else $error("memory control latch wrong");
	vector_a: assert property (io_req.inta |=> io_rvalid && io_rdata == 16'h0043) // RL18
		else $error("wrong interrupt vector");
	rti_hold_a: assert property (rti_req && !io_req.inta |=> rti_req) // RL19
		else $error("interrupt dropped before acknowledge");
	rti_tick_a: assert property (rti_tc |=> rti_req) // RL17
		else $error("divider tick lost");
	eprom_route_a: assert property (mem_rd && !mem_ctl[4] |-> mem_sel.eprom_oe
		&& !mem_sel.flash_oe) // RL11
		else $error("read not sent to eprom");
	shared_map_a: assert property (mem_wr && mem_ctl[3:0] == 4'b1001 && mem_ctl[4]
		|-> mem_sel.ram_we && !mem_sel.flash_we) // RL10
		else $error("write not sent to ram");
	status_read_a: assert property (io_req.rd && io_req.addr == CGD_MEM_CTL_ADDR
		&& !io_req.inta |=> io_rdata[6:5] == 2'b00 && io_rdata[15:8] == 8'h00) // RL12
		else $error("status read wrong");
	wdog_reset_a: assert property (sup_q == CGD_SUP_ARMED && kick_n_q && pg_q
		&& sup_cnt_q == 24'(WDOG_GAP_CYC - 1) |=> !rst_req_n) // RL3
		else $error("watchdog gap did not reset");

	kick_c: cover property (wr_at_wdog ##1 !kick_n);
	rti_ack_c: cover property (rti_req ##1 io_req.inta ##1 !rti_req);
	wdog_expire_c: cover property (sup_q == CGD_SUP_ARMED ##1 sup_q == CGD_SUP_HOLD);
	dip_read_c: cover property (io_req.rd && hit_panel);

endmodule : cgd_io_decode

`default_nettype wire

/* cgd_cpu_model.sv */
// Bus master model of the main processor I/O side
`timescale 1ns/1ps
`default_nettype none

module cgd_cpu_model
	import cgd_pkg::*;
(
	input wire logic clk_sys,
	output var cgd_io_req_s io_req
);
	// ********
	// Access
	// ********
	initial begin
		io_req = '0;
	end

	// Idle bus shows inverted leftovers so stale values never look valid
	task automatic access(input logic [15:0] a, input logic [15:0] d, input logic [2:0] k);
		@(posedge clk_sys);
		#1;
		io_req = '{addr: a, wdata: d, wr: k[2], rd: k[1], inta: k[0]};
		@(posedge clk_sys);
		#1;
		io_req = '{addr: ~a, wdata: ~d, wr: 1'b0, rd: 1'b0, inta: 1'b0};
	endtask : access
endmodule : cgd_cpu_model

`default_nettype wire

/* cgd_io_decode_tb.sv */
// Self-checking bench for the controller glue I/O decode block
`timescale 1ns/1ps
`default_nettype none

module cgd_io_decode_tb
	import cgd_pkg::*;
();
	// ********
	// Signals
	// ********
	localparam int HOLD = 20;
	localparam int GAP = 50;
	localparam int DIV = 16;
	logic clk_sys, resetn, mem_rd, mem_wr, power_good;
	logic [7:0] status_in, mem_ctl;
	logic [31:0] dip_in;
	cgd_io_req_s io_req;
	cgd_mem_sel_s mem_sel;
	logic [15:0] io_rdata, up_sel, mid_sel, low_sel, pg_frame, pg_latch, out_port;
	logic io_rvalid, led_a, led_b, rst_req_n, kick_n, failover, maint, pub_lock, rti_req;
	int num_errors, checked, seed, cnt, n, t1;
	logic [15:0] exp_q[$];
	logic [15:0] sa [6] = '{16'hf400, 16'hf410, 16'hf420, 16'hf430, 16'hf440, 16'hf4b0};
	logic [15:0] sd [6];

	cgd_io_decode #(.POR_HOLD_CYC(HOLD), .WDOG_GAP_CYC(GAP), .RTI_DIVISOR(DIV)) dut (
		.clk_sys(clk_sys), .resetn(resetn), .io_req(io_req), .io_rdata(io_rdata),
		.io_rvalid(io_rvalid), .mem_rd(mem_rd), .mem_wr(mem_wr), .mem_sel(mem_sel),
		.mem_ctl(mem_ctl), .upper_region_select(up_sel), .middle_region_select(mid_sel),
		.lower_region_select(low_sel), .page_frame(pg_frame), .page_latch(pg_latch),
		.out_port(out_port), .status_in(status_in), .dip_in(dip_in),
		.status_led_first(led_a), .status_led_second(led_b), .power_good(power_good),
		.rst_req_n(rst_req_n), .kick_n(kick_n), .failover(failover),
		.maint_failover_en(maint), .pub_lock(pub_lock), .rti_req(rti_req)
	);

	cgd_cpu_model cpu (.clk_sys(clk_sys), .io_req(io_req));

	initial begin
		clk_sys = 1'b0;
		forever #20 clk_sys = ~clk_sys;
	end

	always @(posedge clk_sys) cnt <= cnt + 1;

	// ********
	// Tasks
	// ********
	task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
		checked++;
		if (g !== e) begin
			num_errors++;
			$display("wrong value %s expected %h seen %h", nm, e, g);
		end
	endtask : chk

	task automatic wr(input logic [15:0] a, input logic [15:0] d);
		cpu.access(a, d, 3'b100);
	endtask : wr

	task automatic rd(input logic [15:0] a, input logic [15:0] e);
		exp_q.push_back(e);
		cpu.access(a, 16'h0000, 3'b010);
	endtask : rd

	task automatic ack();
		exp_q.push_back(16'h0043);
		cpu.access(16'h0000, 16'h0000, 3'b001);
	endtask : ack

	task automatic cyc(input int k);
		repeat (k) @(posedge clk_sys);
		#1;
	endtask : cyc

	// Bounded poll, so a dead interrupt cannot hang the run
	task automatic wait_rti();
		n = 0;
		while (rti_req !== 1'b1 && n < 3 * DIV) begin
			cyc(1);
			n++;
		end
	endtask : wait_rti

	task automatic final_report();
		$display("comparisons %0d mismatches %0d", checked, num_errors);
		if (num_errors == 0 && checked > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask : final_report

	// Read data checked against oldest note, between edges
	always @(negedge clk_sys) begin
		if (io_rvalid === 1'b1) begin
			if (exp_q.size() == 0) begin
				chk("unexpected read", 16'h0000, 16'h0001);
			end else begin
				chk("read data", exp_q.pop_front(), io_rdata);
			end
		end
	end

	initial begin
		#(40 * 4000);
		num_errors++;
		$display("timeout");
		final_report();
	end

	// ********
	// Sequence
	// ********
	initial begin
		seed = 32'h2a3cbec0;
		{resetn, power_good, mem_rd, mem_wr, status_in, dip_in} = '0;
		{num_errors, checked} = '0;
		repeat (4) @(posedge clk_sys);
		#1;
		resetn = 1'b1;
		cyc(10);
		chk("rst_req_n", 16'h0000, rst_req_n);
		power_good = 1'b1;
		cyc(HOLD / 2);
		chk("rst_req_n", 16'h0000, rst_req_n);
		cyc(HOLD + 5);
		chk("rst_req_n", 16'h0001, rst_req_n);
		$display("test power hold done");
		for (int i = 0; i < 6; i++) begin
			sd[i] = 16'($random(seed));
			wr(sa[i], sd[i]);
			rd(sa[i], 16'h0000);
		end
		chk("upper", sd[0], up_sel);
		chk("middle", sd[1], mid_sel);
		chk("lower", sd[2], low_sel);
		chk("frame", sd[3], pg_frame);
		chk("latch", sd[4], pg_latch);
		chk("out", sd[5], out_port);
		rd(16'h1000, 16'h0000);
		$display("test registers done");
		status_in = 8'($random(seed));
		wr(16'hf490, 16'hffff);
		chk("mem_ctl", 16'h00df, mem_ctl);
		rd(16'hf490, {8'h00, status_in[7], 2'b00, status_in[4:0]});
		wr(16'hf490, 16'h0019);
		mem_wr = 1'b1;
		cyc(1);
		chk("ram_we", 16'h0001, mem_sel.ram_we);
		chk("flash_we", 16'h0000, mem_sel.flash_we);
		mem_wr = 1'b0;
		mem_rd = 1'b1;
		cyc(1);
		chk("flash_oe", 16'h0001, mem_sel.flash_oe);
		chk("ram_oe", 16'h0000, mem_sel.ram_oe);
		chk("eprom_oe", 16'h0000, mem_sel.eprom_oe);
		mem_rd = 1'b0;
		wr(16'hf490, 16'h0000);
		mem_rd = 1'b1;
		cyc(1);
		chk("eprom_oe", 16'h0001, mem_sel.eprom_oe);
		chk("flash_oe", 16'h0000, mem_sel.flash_oe);
		mem_rd = 1'b0;
		$display("test memory control done");
		dip_in = $random(seed);
		wr(16'h0040, 16'h0002);
		chk("leds", 16'h0002, {led_b, led_a});
		wr(16'h007d, 16'h0001);
		chk("leds", 16'h0001, {led_b, led_a});
		for (int i = 0; i < 4; i++) begin
			rd(16'h0040 + 16'(i), {8'h00, dip_in[8 * i +: 8]});
		end
		rd(16'h007f, {8'h00, dip_in[31:24]});
		rd(16'h0080, 16'h0000);
		wr(16'h0210, 16'h0001);
		chk("maint", 16'h0001, maint);
		wr(16'h0210, 16'h0000);
		chk("maint", 16'h0000, maint);
		wr(16'hf4a0, 16'h0001);
		chk("lock", 16'h0001, pub_lock);
		wr(16'hf4a0, 16'h0000);
		chk("lock", 16'h0000, pub_lock);
		$display("test panel and ports done");
		wait_rti();
		ack();
		chk("rti_req", 16'h0000, rti_req);
		wait_rti();
		t1 = cnt;
		cyc(3);
		chk("rti_req", 16'h0001, rti_req);
		ack();
		wait_rti();
		chk("rti period", 16'(DIV), 16'(cnt - t1));
		$display("test interrupt done");
		wr(16'h0200, 16'h0000);
		chk("kick_n", 16'h0000, kick_n);
		chk("failover", 16'h0001, failover);
		cyc(1);
		chk("kick_n", 16'h0001, kick_n);
		wr(16'h0200, 16'h0001);
		chk("failover", 16'h0000, failover);
		for (int i = 0; i < 3; i++) begin
			cyc(GAP - 20);
			wr(16'h0200, 16'h0001);
			chk("rst_req_n", 16'h0001, rst_req_n);
		end
		cyc(GAP - 5);
		chk("rst_req_n", 16'h0001, rst_req_n);
		cyc(10);
		chk("rst_req_n", 16'h0000, rst_req_n);
		cyc(HOLD + 5);
		chk("rst_req_n", 16'h0001, rst_req_n);
		$display("test watchdog done");
		chk("pending reads", 16'h0000, 16'(exp_q.size()));
		final_report();
	end
endmodule : cgd_io_decode_tb

`default_nettype wire
